/* File: rtl/bcwp_pkg.sv */
// Purpose: Shared constants and types for the block code and write protection configuration.
// Assumes: Byte-wide configuration cells reached over a plain register port.
// Notes: Addresses are the byte addresses of the configuration space.
package bcwp_pkg;

  localparam int unsigned ADDR_W = 22;
  localparam logic [21:0] CP_LOW_ADDR = 22'h300008;
  localparam logic [21:0] CP_HIGH_ADDR = 22'h300009;
  localparam logic [21:0] WP_LOW_ADDR = 22'h30000a;

  localparam logic [3:0] CP_LOW_RESET = 4'hf;
  localparam logic [1:0] CP_HIGH_RESET = 2'h3;
  localparam logic [3:0] WP_LOW_RESET = 4'hf;

  localparam int unsigned BLOCK_LSB = 0;
  localparam int unsigned BLOCK_MSB = 3;
  localparam int unsigned BOOT_POS = 6;
  localparam int unsigned EEPROM_POS = 7;

  localparam logic [7:0] READ_BLOCKED = 8'h00;

  typedef enum logic [1:0] {
    BCWP_REGION_BLOCK = 2'b00,
    BCWP_REGION_BOOT = 2'b01,
    BCWP_REGION_EEPROM = 2'b10
  } bcwp_region_e;

  typedef struct packed {
    bcwp_region_e region;
    logic [1:0] block;
  } bcwp_target_s;

  typedef struct packed {
    logic [3:0] block_read_guard;
    logic boot_read_guard;
    logic eeprom_read_guard;
    logic [3:0] block_write_guard;
  } bcwp_guards_s;

endpackage

/* File: rtl/bcwp_cell.sv */
// Purpose: One nonvolatile-style configuration bit with a chosen write policy.
// Assumes: Writes arrive as one-cycle strobes on core_clk_i.
// Notes: Clear-only cells can move from 1 to 0 and never back.
`timescale 1ns/100ps
module bcwp_cell import bcwp_pkg::*; #(
  parameter bit CLEAR_ONLY = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic din_i,
  output logic q_o
);

  logic bit_r;
  logic bit_nxt;

  // Clear-only cells AND the new value in, so a 0 can never return to 1.
  assign bit_nxt = !wr_i ? bit_r : (CLEAR_ONLY ? (bit_r & din_i) : din_i);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_r <= 1'b1;
    end else begin
      bit_r <= bit_nxt;
    end
  end

  assign q_o = bit_r;

  chk_cell_clear_only: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    CLEAR_ONLY && !$past(bit_r) |-> !bit_r)
    else $error("clear-only cell returned to one");

endmodule // bcwp_cell

/* File: rtl/bcwp_guard.sv */
// Purpose: Decides whether one memory access is refused or blocked.
// Assumes: Guard bits are 1 when unprotected.
// Notes: Pure combinational decode.
`timescale 1ns/100ps
module bcwp_guard import bcwp_pkg::*; (
  input bcwp_target_s target_i,
  input bcwp_guards_s guards_i,
  output logic read_ok_o,
  output logic write_ok_o
);

  wire logic blk_read_ok;
  wire logic blk_write_ok;

  assign blk_read_ok = guards_i.block_read_guard[target_i.block];
  assign blk_write_ok = guards_i.block_write_guard[target_i.block];

  assign read_ok_o = (target_i.region == BCWP_REGION_BLOCK) ? blk_read_ok :
                     (target_i.region == BCWP_REGION_BOOT) ? guards_i.boot_read_guard :
                     (target_i.region == BCWP_REGION_EEPROM) ? guards_i.eeprom_read_guard : 1'b0;
  assign write_ok_o = (target_i.region == BCWP_REGION_BLOCK) ? blk_write_ok : 1'b1;

endmodule // bcwp_guard

/* File: rtl/bcwp_config.sv */
// Purpose: Holds code and write protection configuration bytes and applies them to memory accesses.
// Assumes: Programming writes come over the register port; the access port is driven by memory logic.
// Notes: Reset stands in for the unprogrammed erased state of the cells.
`timescale 1ns/100ps

module bcwp_config import bcwp_pkg::*; (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [21:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic acc_req_i,
  input wire logic acc_write_i,
  input bcwp_target_s acc_target_i,
  input wire logic [7:0] acc_rdata_i,
  output logic acc_write_ok_o,
  output logic acc_read_ok_o,
  output logic [7:0] acc_rdata_o,
  output bcwp_guards_s guards_o
);

  // ==========================================================
  // Register decode.
  wire logic sel_cp_low;
  wire logic sel_cp_high;
  wire logic sel_wp_low;
  wire logic wr_cp_low;
  wire logic wr_cp_high;
  wire logic wr_wp_low;

  assign sel_cp_low = (reg_addr_i == CP_LOW_ADDR);
  assign sel_cp_high = (reg_addr_i == CP_HIGH_ADDR);
  assign sel_wp_low = (reg_addr_i == WP_LOW_ADDR);
  assign wr_cp_low = reg_wr_i & sel_cp_low;
  assign wr_cp_high = reg_wr_i & sel_cp_high;
  assign wr_wp_low = reg_wr_i & sel_wp_low;

  // ==========================================================
  // Protection cells.
  wire logic [3:0] cp_block;
  logic cp_boot;
  logic cp_eeprom;
  wire logic [3:0] wp_block;

  // Code cells only clear, while write cells take any value, so write protection can be lifted again.
  genvar gi;
  generate
    for (gi = BLOCK_LSB; gi <= BLOCK_MSB; gi++) begin : g_block
      bcwp_cell #(.CLEAR_ONLY(1'b1)) u_cp (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(wr_cp_low),
        .din_i(reg_wdata_i[gi]),
        .q_o(cp_block[gi])
      );
      bcwp_cell #(.CLEAR_ONLY(1'b0)) u_wp (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(wr_wp_low),
        .din_i(reg_wdata_i[gi]),
        .q_o(wp_block[gi])
      );
    end
  endgenerate

  bcwp_cell #(.CLEAR_ONLY(1'b1)) u_cp_boot (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_cp_high),
    .din_i(reg_wdata_i[BOOT_POS]),
    .q_o(cp_boot)
  );

  bcwp_cell #(.CLEAR_ONLY(1'b1)) u_cp_eeprom (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_cp_high),
    .din_i(reg_wdata_i[EEPROM_POS]),
    .q_o(cp_eeprom)
  );

  // ==========================================================
  // Read-back path.
  wire logic [7:0] cp_low_view;
  wire logic [7:0] cp_high_view;
  wire logic [7:0] wp_low_view;
  wire logic [7:0] rd_mux;

  assign cp_low_view = {4'h0, cp_block};
  assign cp_high_view = {cp_eeprom, cp_boot, 6'h00};
  assign wp_low_view = {4'h0, wp_block};
  assign rd_mux = sel_cp_low ? cp_low_view :
                  sel_cp_high ? cp_high_view :
                  sel_wp_low ? wp_low_view : 8'h00;

  // Read data drop to zero outside the cycle after a read, so stale bytes never linger.
  logic [7:0] rdata_r;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ==========================================================
  // Access guarding.
  bcwp_guards_s guards;
  logic read_ok;
  logic write_ok;
  logic [7:0] acc_rdata_r;

  // One assignment drives the whole struct, so it has a single driver.
  assign guards = '{
    block_read_guard: cp_block,
    boot_read_guard: cp_boot,
    eeprom_read_guard: cp_eeprom,
    block_write_guard: wp_block
  };
  assign guards_o = guards;

  bcwp_guard u_guard (
    .target_i(acc_target_i),
    .guards_i(guards),
    .read_ok_o(read_ok),
    .write_ok_o(write_ok)
  );

  // Handshake answers are combinational so memory logic can gate in the same cycle.
  assign acc_write_ok_o = acc_req_i & acc_write_i & write_ok;
  assign acc_read_ok_o = acc_req_i & ~acc_write_i & read_ok;

  // Read data hold between reads, so memory logic may take them late.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_rdata_r <= 8'h00;
    end else if (acc_req_i && !acc_write_i) begin
      acc_rdata_r <= read_ok ? acc_rdata_i : READ_BLOCKED;
    end
  end

  assign acc_rdata_o = acc_rdata_r;

  // ==========================================================
  // Checks.
  sequence s_cp_low_read;
    reg_rd_i && sel_cp_low;
  endsequence

  chk_cp_low_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_cp_low_read |=> reg_rdata_o[7:4] == 4'h0)
    else $error("code low upper bits not zero");

  chk_cp_high_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && sel_cp_high |=> reg_rdata_o[5:0] == 6'h00)
    else $error("code high lower bits not zero");

  chk_cp_low_value: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_cp_low_read |=> reg_rdata_o[3:0] == $past(cp_block))
    else $error("code low read value wrong");

  chk_cp_never_sets: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cp_low |=> (cp_block & ~$past(cp_block)) == 4'h0)
    else $error("code protection bit set by write");

  chk_eeprom_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    acc_req_i && !acc_write_i && acc_target_i.region == BCWP_REGION_EEPROM && !cp_eeprom
      |=> acc_rdata_o == READ_BLOCKED)
    else $error("protected eeprom read not blocked");

  chk_boot_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    acc_req_i && acc_target_i.region == BCWP_REGION_BOOT |-> !acc_read_ok_o || cp_boot)
    else $error("protected boot read allowed");

  chk_wp_program: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_wp_low |=> wp_block == $past(reg_wdata_i[3:0]))
    else $error("write protection not programmed");

  chk_wp_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !wr_wp_low |=> $stable(wp_block))
    else $error("write protection changed without write");

  chk_write_refuse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    acc_req_i && acc_write_i && acc_target_i.region == BCWP_REGION_BLOCK &&
      !wp_block[acc_target_i.block] |-> !acc_write_ok_o)
    else $error("write into protected block allowed");

  chk_block_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    acc_req_i && !acc_write_i && acc_target_i.region == BCWP_REGION_BLOCK &&
      !cp_block[acc_target_i.block] |=> acc_rdata_o == READ_BLOCKED)
    else $error("protected block read not blocked");

  // ==========================================================
  // Read-back, write and hold checks.
  sequence s_cp_high_read;
    reg_rd_i && sel_cp_high;
  endsequence

  sequence s_wp_low_read;
    reg_rd_i && sel_wp_low;
  endsequence

  chk_wp_low_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_wp_low_read |=> reg_rdata_o[7:4] == 4'h0)
    else $error("write low upper bits not zero");

  chk_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && !sel_cp_low && !sel_cp_high && !sel_wp_low |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  chk_rdata_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data present without read");

  chk_eeprom_readback: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_cp_high_read |=> reg_rdata_o[7] == $past(cp_eeprom))
    else $error("eeprom guard read value wrong");

  chk_boot_readback: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_cp_high_read |=> reg_rdata_o[6] == $past(cp_boot))
    else $error("boot guard read value wrong");

  chk_wp_low_value: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_wp_low_read |=> reg_rdata_o[3:0] == $past(wp_block))
    else $error("write low read value wrong");

  chk_cp_clear_lands: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cp_low |=> cp_block == ($past(cp_block) & $past(reg_wdata_i[3:0])))
    else $error("code protection clear not applied");

  chk_high_never_sets: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cp_high |=> !(cp_eeprom && !$past(cp_eeprom)) &&
      !(cp_boot && !$past(cp_boot)))
    else $error("high code protection bit set by write");

  chk_cp_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !wr_cp_low |=> $stable(cp_block))
    else $error("code low changed without write");

  chk_cp_high_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !wr_cp_high |=> $stable(cp_eeprom) && $stable(cp_boot))
    else $error("code high changed without write");

  // ==========================================================
  // Access checks.
  sequence s_acc_read;
    acc_req_i && !acc_write_i;
  endsequence

  sequence s_acc_write;
    acc_req_i && acc_write_i;
  endsequence

  chk_eeprom_read_ok: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_acc_read ##0 (acc_target_i.region == BCWP_REGION_EEPROM)
      |-> acc_read_ok_o == cp_eeprom)
    else $error("eeprom read answer wrong");

  chk_boot_pass: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_acc_read ##0 (acc_target_i.region == BCWP_REGION_BOOT && cp_boot)
      |=> acc_rdata_o == $past(acc_rdata_i))
    else $error("open boot read not passed");

  chk_block_pass: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_acc_read ##0 (acc_target_i.region == BCWP_REGION_BLOCK && cp_block[acc_target_i.block])
      |=> acc_rdata_o == $past(acc_rdata_i))
    else $error("open block read not passed");

  chk_block_write_ok: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_acc_write ##0 (acc_target_i.region == BCWP_REGION_BLOCK)
      |-> acc_write_ok_o == wp_block[acc_target_i.block])
    else $error("block write answer wrong");

  chk_idle_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !acc_req_i |-> !acc_write_ok_o && !acc_read_ok_o)
    else $error("access answer without request");

  chk_rdata_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(acc_req_i && !acc_write_i) |=> $stable(acc_rdata_o))
    else $error("access data changed without read");

  chk_spare_region: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_acc_read ##0 (acc_target_i.region == bcwp_region_e'(2'b11))
      |-> !acc_read_ok_o)
    else $error("spare region read allowed");

  chk_other_write_ok: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_acc_write ##0 (acc_target_i.region != BCWP_REGION_BLOCK) |-> acc_write_ok_o)
    else $error("non-block write refused");

endmodule // bcwp_config

/* File: test/bcwp_config_test.sv */
// Purpose: Self-checking bench for the code and write protection configuration block.
// Assumes: Register port with one-cycle strobes; read data stand in the cycle after the strobe.
// Notes: Reset stands in for the erased state of the cells.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module bcwp_config_test import bcwp_pkg::*;;
  // ==========================================================================
  // Signals and design
  logic core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, acc_req_i, acc_write_i;
  logic [21:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, acc_rdata_i, acc_rdata_o, d;
  logic acc_write_ok_o, acc_read_ok_o;
  bcwp_target_s acc_target_i, t;
  bcwp_guards_s guards_o;
  int error_cnt, checks;
  logic [37:0] rows [8] = '{{WP_LOW_ADDR, 8'hf5, 8'h05}, {WP_LOW_ADDR, 8'hfa, 8'h0a},
    {CP_LOW_ADDR, 8'hfe, 8'h0e}, {CP_LOW_ADDR, 8'hff, 8'h0e}, {CP_LOW_ADDR, 8'hf3, 8'h02},
    {CP_HIGH_ADDR, 8'h7f, 8'h40}, {CP_HIGH_ADDR, 8'hff, 8'h40}, {22'h30000b, 8'hff, 8'h00}};
  logic [3:0] cp = 4'h2;
  logic [3:0] wp = 4'ha;

  bcwp_config i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .acc_req_i(acc_req_i), .acc_write_i(acc_write_i), .acc_target_i(acc_target_i),
    .acc_rdata_i(acc_rdata_i), .acc_write_ok_o(acc_write_ok_o), .acc_read_ok_o(acc_read_ok_o),
    .acc_rdata_o(acc_rdata_o), .guards_o(guards_o));

  // ==========================================================================
  // Bus and access tasks; each starts and ends at a rising edge.
  task automatic wr(input logic [21:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // The read value is taken mid-cycle, in the one cycle in which it stands.
  task automatic rd(input logic [21:0] a, output logic [7:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    v = reg_rdata_o;
    @(posedge core_clk_i);
  endtask

  task automatic acc(input bcwp_target_s tg, input logic w, input logic ok);
    acc_req_i <= 1'b1;
    acc_write_i <= w;
    acc_target_i <= tg;
    acc_rdata_i <= 8'h50 + {4'h0, tg};
    #1;
    if (w) `CHK("write ok", ok, acc_write_ok_o)
    else `CHK("read ok", ok, acc_read_ok_o)
    @(posedge core_clk_i);
    acc_req_i <= 1'b0;
    @(posedge core_clk_i);
    if (!w) `CHK("access data", ok ? 8'h50 + {4'h0, tg} : READ_BLOCKED, acc_rdata_o)
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  initial begin
    repeat (2000) @(posedge core_clk_i);
    error_cnt++;
    wrap_up();
  end

  initial begin
    error_cnt = 0;
    checks = 0;
    rst_n_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    acc_req_i = 1'b0;
    acc_write_i = 1'b0;
    acc_target_i = '0;
    acc_rdata_i = '0;
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd(CP_LOW_ADDR, d); `CHK("code low erased", 8'h0f, d)
    rd(CP_HIGH_ADDR, d); `CHK("code high erased", 8'hc0, d)
    rd(WP_LOW_ADDR, d); `CHK("write low erased", 8'h0f, d)
    `CHK("guards erased", 10'h3ff, guards_o)
    `CHK("idle answers", 2'b00, {acc_write_ok_o, acc_read_ok_o})
    // Each row writes one byte and reads it straight back.
    foreach (rows[i]) begin
      wr(rows[i][37:16], rows[i][15:8]);
      rd(rows[i][37:16], d); `CHK("readback", rows[i][7:0], d)
    end
    rd(CP_LOW_ADDR, d); `CHK("code low kept", 8'h02, d)
    rd(CP_HIGH_ADDR, d); `CHK("code high kept", 8'h40, d)
    rd(WP_LOW_ADDR, d); `CHK("write low kept", 8'h0a, d)
    `CHK("guards", 10'h0aa, guards_o)
    for (int i = 0; i < 4; i++) begin
      t.region = BCWP_REGION_BLOCK;
      t.block = i[1:0];
      acc(t, 1'b0, cp[i]);
      acc(t, 1'b1, wp[i]);
    end
    t.region = BCWP_REGION_EEPROM;
    acc(t, 1'b0, 1'b0);
    t.region = BCWP_REGION_BOOT;
    acc(t, 1'b0, 1'b1);
    // A second reset brings back the erased state in mid-run.
    rst_n_i <= 1'b0;
    #1;
    `CHK("guards after reset", 10'h3ff, guards_o)
    `CHK("data after reset", 8'h00, acc_rdata_o)
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd(CP_HIGH_ADDR, d); `CHK("code high reset", 8'hc0, d)
    // A small part keeps the block 2 and block 3 bits at 1.
    wr(WP_LOW_ADDR, 8'hfc);
    rd(WP_LOW_ADDR, d); `CHK("small part write low", 8'h0c, d)
    wr(CP_LOW_ADDR, 8'h0d);
    rd(CP_LOW_ADDR, d); `CHK("small part code low", 8'h0d, d)
    t = '{region: BCWP_REGION_BLOCK, block: 2'b01};
    acc(t, 1'b0, 1'b0);
    acc(t, 1'b1, 1'b0);
    t.region = BCWP_REGION_BOOT;
    acc(t, 1'b1, 1'b1);
    t.region = bcwp_region_e'(2'b11);
    acc(t, 1'b0, 1'b0);
    wrap_up();
  end
endmodule // bcwp_config_test
